// File: design/apc_control.sv
// Access port control and direct window logic, slave register port to APB master.
// Assumes a request strobe on the slave side held with stable
// address and data until the ready pulse, and APB4 slaves on the master side.
// Assumes the data path ends each data register access with a one-cycle pulse.
`timescale 1ns/1ps
module apc_control
   import apc_pkg::*;
(
   // Clock and synchronous reset
   input wire logic core_clk,
   input wire logic rst,
   // Enable inputs from the system
   input wire logic port_enable_in,
   input wire logic secure_port_enable_in,
   // Slave register port, request held until ready
   input wire logic s_req,
   input wire logic s_write,
   input wire logic [11:0] s_addr,
   input wire logic [31:0] s_wdata,
   output logic s_ready,
   output logic [31:0] s_rdata,
   output logic s_err,
   // APB master interface
   output logic [31:0] m_paddr,
   output logic m_psel,
   output logic m_penable,
   output logic m_pwrite,
   output logic [31:0] m_pwdata,
   output logic [2:0] m_pprot,
   output logic [3:0] m_pstrb,
   // Replies from the memory system
   input wire logic [31:0] m_prdata,
   input wire logic m_pready,
   input wire logic m_pslverr,
   // End of a data register access, from the data path
   input wire logic data_access_done,
   input wire logic data_access_err,
   input wire logic data_access_abort
);
   apc_state_t state_reg; // Master transfer state
   logic [2:0] prot_reg; // Protection field
   logic halt_on_error_reg; // Stop further window accesses after an error
   logic suppress_error_upstream_reg; // Keep errors from requester
   logic [3:0] mode_reg; // Operating mode
   logic [1:0] auto_increment_reg; // Address increment selection
   logic [31:0] transfer_address_reg; // Transfer address
   logic err_latched_reg; // A memory error has been seen
   logic port_enable_status; // Port enable view
   logic secure_enable_status; // Both enables view
   logic access_permitted; // Master access allowed now
   logic transfer_active; // Transfer outstanding on master side
   logic [31:0] ctrl_word; // Read view of the control word
   logic memory_blocked; // Halt on error is in force
   // Request decode and transfer events
   logic slave_take; // Request taken this cycle
   logic window_hit; // Request targets the last window word
   logic window_go; // Permitted window access starts a transfer
   logic window_refused; // Window access answered without a transfer
   logic reg_access; // Register-only access
   logic ctrl_write; // Software write to the control word
   logic addr_write; // Software write to the transfer address
   logic master_done; // Master transfer completes this cycle
   logic clean_finish; // Data access ended with no error or abort
   logic mem_error; // Memory access error seen this cycle
   logic [31:0] reg_read_data; // Register read value

   // Enable views shown in the control word
   assign port_enable_status = port_enable_in;
   assign secure_enable_status = port_enable_in & secure_port_enable_in;
   // Secure access only with both enables, nonsecure with port enable alone
   assign access_permitted = secure_enable_status | (port_enable_in & prot_reg[1]);
   // Outstanding from setup until ready is seen
   assign transfer_active = (state_reg == APC_SETUP) | (state_reg == APC_ACCESS);
   // Only an error latched under halt on error blocks memory accesses
   assign memory_blocked = halt_on_error_reg & err_latched_reg;

   // A request is taken only in idle, never during a transfer or its answer
   assign slave_take = s_req & (state_reg == APC_IDLE);
   // The last window word is the only memory word reached here
   assign window_hit = (s_addr == APC_OFF_WINDOW_LAST);
   // Window accesses start a transfer only when allowed and not halted
   assign window_go = slave_take & window_hit & access_permitted & ~memory_blocked;
   assign window_refused = slave_take & window_hit & ~(access_permitted & ~memory_blocked);
   assign reg_access = slave_take & ~window_hit;
   // Software writes land on the taking edge only
   assign ctrl_write = slave_take & s_write & (s_addr == APC_OFF_CTRL_WORD);
   assign addr_write = slave_take & s_write & (s_addr == APC_OFF_XFER_ADDR);
   // Ready seen in the access phase ends the master transfer
   assign master_done = (state_reg == APC_ACCESS) & m_pready;
   // A data register access that ended with no error and no abort
   assign clean_finish = data_access_done & ~data_access_err & ~data_access_abort;
   // Errors from the master side or from a data register access
   assign mem_error = (master_done & m_pslverr) | (data_access_done & data_access_err);

   // Assemble the control word; reserved fields stay zero
   always_comb
   begin
      ctrl_word = 32'h00000000;
      // Protection and the secure enable view
      ctrl_word[APC_PROT_HI:APC_PROT_LO] = prot_reg;
      ctrl_word[APC_SEC_STAT_BIT] = secure_enable_status;
      // Error handling controls
      ctrl_word[APC_HALT_ERR_BIT] = halt_on_error_reg;
      ctrl_word[APC_SUPP_ERR_BIT] = suppress_error_upstream_reg;
      // Mode, transfer status and enable status
      ctrl_word[APC_MODE_HI:APC_MODE_LO] = mode_reg;
      ctrl_word[APC_ACTIVE_BIT] = transfer_active;
      ctrl_word[APC_EN_STAT_BIT] = port_enable_status;
      // Increment mode and the fixed word size
      ctrl_word[APC_INC_HI:APC_INC_LO] = auto_increment_reg;
      ctrl_word[APC_SIZE_HI:APC_SIZE_LO] = APC_SIZE_WORD;
   end

   // Read value on the register port; writes and unmapped offsets give zero
   always_comb
   begin
      reg_read_data = 32'h00000000;
      if (!s_write)
      begin
         // Only the control word and the transfer address read back here
         case (s_addr)
            APC_OFF_CTRL_WORD: reg_read_data = ctrl_word;
            APC_OFF_XFER_ADDR: reg_read_data = transfer_address_reg;
            default: reg_read_data = 32'h00000000;
         endcase
      end
   end

   // Control word fields written by software
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         prot_reg <= APC_PROT_RST;
         halt_on_error_reg <= 1'b0;
         suppress_error_upstream_reg <= 1'b0;
         mode_reg <= APC_MODE_RST;
         auto_increment_reg <= APC_INC_RST;
      end
      else if (ctrl_write)
      begin
         // Reserved and read-only bits are not stored
         prot_reg <= s_wdata[APC_PROT_HI:APC_PROT_LO];
         halt_on_error_reg <= s_wdata[APC_HALT_ERR_BIT];
         suppress_error_upstream_reg <= s_wdata[APC_SUPP_ERR_BIT];
         mode_reg <= s_wdata[APC_MODE_HI:APC_MODE_LO];
         auto_increment_reg <= s_wdata[APC_INC_HI:APC_INC_LO];
      end
   end

   // Transfer address: software write or increment after a clean data access
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         transfer_address_reg <= 32'h00000000;
      end
      // A software write wins over an increment in the same cycle
      else if (addr_write)
      begin
         transfer_address_reg <= s_wdata;
      end
      // Single increment steps one word
      else if (clean_finish && auto_increment_reg == APC_INC_SINGLE)
      begin
         transfer_address_reg <= transfer_address_reg + APC_WORD_STEP;
      end
   end

   // Sticky memory error; errors count only while halt on error is on
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         err_latched_reg <= 1'b0;
      end
      else if (mem_error && halt_on_error_reg)
      begin
         // A new error wins over a clear in the same cycle
         err_latched_reg <= 1'b1;
      end
      else if (ctrl_write && !s_wdata[APC_HALT_ERR_BIT])
      begin
         // Turning halt on error off releases the window again
         err_latched_reg <= 1'b0;
      end
   end

   // Timing of a permitted window access, counted from the taking edge:
   // the taking edge itself puts select, address, direction and data on the master side,
   // the edge after that raises enable for the access phase,
   // the edge with ready high drops select and enable and raises the answer,
   // and the next edge returns to idle. Taking requests only in idle keeps a
   // strobe still held through the answer from starting a second access.
   // Transfer sequence: setup, access until ready, then one answer cycle
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_reg <= APC_IDLE;
      end
      else
      begin
         unique case (state_reg)
            APC_IDLE:
            begin
               // Refused window and register accesses answer at once
               if (window_go)
               begin
                  state_reg <= APC_SETUP;
               end
               else if (slave_take)
               begin
                  state_reg <= APC_DONE;
               end
            end
            APC_SETUP:
            begin
               // Access phase always follows setup
               state_reg <= APC_ACCESS;
            end
            APC_ACCESS:
            begin
               // Wait states keep the access phase
               if (m_pready)
               begin
                  state_reg <= APC_DONE;
               end
            end
            APC_DONE:
            begin
               // One answer cycle lets the requester drop its strobe
               state_reg <= APC_IDLE;
            end
         endcase
      end
   end

   // APB master signals: launched on a permitted window access, dropped on ready
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         m_paddr <= 32'h00000000;
         m_psel <= 1'b0;
         m_penable <= 1'b0;
         m_pwrite <= 1'b0;
         m_pwdata <= 32'h00000000;
      end
      else if (window_go)
      begin
         // Upper bits from transfer address, low bits from window offset
         m_paddr <= (transfer_address_reg & APC_WINDOW_MASK) + APC_WINDOW_LAST_OFS;
         m_pwrite <= s_write;
         m_pwdata <= s_wdata;
         m_psel <= 1'b1;
      end
      else if (state_reg == APC_SETUP)
      begin
         // Access phase one cycle after setup
         m_penable <= 1'b1;
      end
      else if (master_done)
      begin
         // Transfer ends on ready; address and data keep their last value
         m_psel <= 1'b0;
         m_penable <= 1'b0;
      end
   end

   // Slave answer: one-cycle ready and error, read data held to the next answer
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_ready <= 1'b0;
         s_rdata <= 32'h00000000;
         s_err <= 1'b0;
      end
      else if (master_done)
      begin
         // Memory reply completes the window access
         s_ready <= 1'b1;
         s_rdata <= m_pwrite ? 32'h00000000 : m_prdata;
         s_err <= m_pslverr && !suppress_error_upstream_reg;
      end
      else if (window_refused)
      begin
         // Refused window access: no master transfer, zero data
         s_ready <= 1'b1;
         s_rdata <= 32'h00000000;
         s_err <= !suppress_error_upstream_reg;
      end
      else if (reg_access)
      begin
         // Register-only accesses proceed regardless of enables
         s_ready <= 1'b1;
         s_rdata <= reg_read_data;
         s_err <= 1'b0;
      end
      else
      begin
         // Answer strobes last one cycle
         s_ready <= 1'b0;
         s_err <= 1'b0;
      end
   end

   // Protection follows the control word one cycle later; only whole words move
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         m_pprot <= APC_PROT_RST;
         m_pstrb <= 4'h0;
      end
      else
      begin
         m_pprot <= prot_reg;
         // Strobes are set when a write request is taken and held through the transfer
         m_pstrb <= (slave_take && s_write) ? 4'hf
                    : (state_reg == APC_IDLE) ? 4'h0 : m_pstrb;
      end
   end
endmodule

// File: design/apc_pkg.sv
// Package for the access port control block: register offsets, control word
// field positions and reset values. Assumes a 32-bit slave register port.
package apc_pkg;
   // Register offsets on the slave side (12-bit byte offsets)
   localparam logic [11:0] APC_OFF_WINDOW_LAST = 12'h3fc;
   localparam logic [11:0] APC_OFF_CTRL_WORD = 12'hd00;
   localparam logic [11:0] APC_OFF_XFER_ADDR = 12'hd04;
   // Window address formation
   localparam logic [31:0] APC_WINDOW_MASK = 32'hfffffc00;
   localparam logic [31:0] APC_WINDOW_LAST_OFS = 32'h000003fc;
   // Control word field positions
   localparam int APC_PROT_HI = 30;
   localparam int APC_PROT_LO = 28;
   localparam int APC_SEC_STAT_BIT = 23;
   localparam int APC_HALT_ERR_BIT = 17;
   localparam int APC_SUPP_ERR_BIT = 16;
   localparam int APC_MODE_HI = 11;
   localparam int APC_MODE_LO = 8;
   localparam int APC_ACTIVE_BIT = 7;
   localparam int APC_EN_STAT_BIT = 6;
   localparam int APC_INC_HI = 5;
   localparam int APC_INC_LO = 4;
   localparam int APC_SIZE_HI = 2;
   localparam int APC_SIZE_LO = 0;
   // Reset and fixed values
   localparam logic [2:0] APC_PROT_RST = 3'h3;
   localparam logic [3:0] APC_MODE_RST = 4'h0;
   localparam logic [1:0] APC_INC_RST = 2'h0;
   localparam logic [1:0] APC_INC_SINGLE = 2'h1;
   localparam logic [2:0] APC_SIZE_WORD = 3'h2;
   localparam logic [31:0] APC_WORD_STEP = 32'h00000004;
   // Transfer state machine
   typedef enum logic [1:0] {APC_IDLE, APC_SETUP, APC_ACCESS, APC_DONE} apc_state_t;
endpackage

// File: dv/apc_apb_mem.sv
// APB memory slave model for the master side of the access port control block.
// Wait states and error replies are set by the testbench.
`timescale 1ns/1ps
module apc_apb_mem (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic m_psel,
   input wire logic m_penable,
   input wire logic m_pwrite,
   input wire logic [31:0] m_paddr,
   input wire logic [31:0] m_pwdata,
   input wire logic [1:0] stall,
   input wire logic fail,
   output logic [31:0] m_prdata,
   output logic m_pready,
   output logic m_pslverr,
   output logic [31:0] last_addr,
   output logic [31:0] last_wdata
);
   logic [31:0] mem [0:255]; // Word store
   logic [1:0] wait_reg; // Wait states spent so far
   logic [31:0] junk_reg; // Changing read data outside replies
   assign m_pready = m_psel && m_penable && wait_reg == stall;
   assign m_pslverr = m_pready && fail;
   assign m_prdata = (m_pready && !m_pwrite) ? mem[m_paddr[9:2]] : junk_reg;
   // Count wait states of the access phase
   always_ff @(posedge core_clk)
      if (rst || !(m_psel && m_penable && !m_pready))
         wait_reg <= 2'h0;
      else
         wait_reg <= wait_reg + 2'h1;
   // Read data is never left holding a stale value
   always_ff @(posedge core_clk)
      junk_reg <= rst ? 32'h0f0f0f0f : ~junk_reg;
   // Record each completed transfer; failed writes do not store
   always_ff @(posedge core_clk)
   begin
      if (m_pready)
         last_addr <= m_paddr;
      if (m_pready && m_pwrite)
         last_wdata <= m_pwdata;
      if (m_pready && m_pwrite && !fail)
         mem[m_paddr[9:2]] <= m_pwdata;
   end
endmodule

// File: dv/apc_control_asserts.sv
// Checker for the access port control block: APB master and slave handshakes.
// Bound to every apc_control instance; sees only that module's ports.
`timescale 1ns/1ps
module apc_control_asserts
   import apc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic port_enable_in,
   input wire logic secure_port_enable_in,
   input wire logic s_req,
   input wire logic s_ready,
   input wire logic s_err,
   input wire logic m_psel,
   input wire logic m_penable,
   input wire logic m_pwrite,
   input wire logic [2:0] m_pprot,
   input wire logic [3:0] m_pstrb,
   input wire logic m_pready
);
   // One clock domain, reset quiets every check except pprot_reset_a
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Reset value must show even while reset is held
   pprot_reset_a: assert property (disable iff (1'b0) rst |=> m_pprot == APC_PROT_RST) else $error("bad pprot");
   off_quiet_a: assert property (!port_enable_in && !m_psel |=> !m_psel) else $error("xfer while off");
   // A transfer starts only from an allowed request
   sec_permit_a: assert property ($rose(m_psel) |-> $past(port_enable_in)
      && ($past(secure_port_enable_in) || m_pprot[1])) else $error("xfer not permitted");
   req_cause_a: assert property ($rose(m_psel) |-> $past(s_req)) else $error("xfer without request");
   setup_access_a: assert property ($rose(m_psel) |=> m_psel && m_penable) else $error("no access phase");
   wait_hold_a: assert property (m_penable && !m_pready |=> m_psel && m_penable) else $error("xfer dropped");
   // Slave answer follows the master completion at once
   slave_done_a: assert property (m_penable && m_pready |=> s_ready && !m_psel) else $error("late answer");
   err_ready_a: assert property (s_err |-> s_ready) else $error("stray error");
   ready_pulse_a: assert property (s_ready |=> !s_ready) else $error("long ready");
   word_strobe_a: assert property (m_psel |-> m_pstrb == (m_pwrite ? 4'hf : 4'h0)) else $error("bad strobe");
   // Main scenarios
   cover property (m_penable && m_pready && !m_pwrite);
   cover property (s_ready && s_err);
   cover property (s_ready && !port_enable_in);
endmodule
bind apc_control apc_control_asserts u_chk (.*);

// File: dv/test_apb_access_port_control.sv
// Testbench for the access port control block: registers, window, permissions,
// error halt and increment. Uses the APB memory model on the master side.
`timescale 1ns/1ps
module test_apb_access_port_control;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic port_enable_in = 1'b1;
   logic secure_port_enable_in = 1'b1;
   logic s_req = 1'b0, s_write = 1'b0, fail = 1'b0;
   logic [11:0] s_addr = 12'h000;
   logic [31:0] s_wdata = 32'h0, s_rdata, m_paddr, m_pwdata, m_prdata, last_addr, last_wdata;
   logic s_ready, s_err, m_psel, m_penable, m_pwrite, m_pready, m_pslverr;
   logic [2:0] m_pprot;
   logic [3:0] m_pstrb;
   logic data_access_done = 1'b0, data_access_err = 1'b0, data_access_abort = 1'b0;
   logic [1:0] stall = 2'h0;
   int num_errors = 0, tests_run = 0, cycles = 0;
   apc_control u_dut (.*);
   apc_apb_mem u_mem (.*);
   always #5 core_clk = ~core_clk;
   // Cut a hang short
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One slave access, held until ready; read data checked on reads only
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, er, input logic ee);
      s_req <= 1'b1;
      s_write <= w;
      s_addr <= a;
      s_wdata <= d;
      @(posedge core_clk iff s_ready === 1'b1);
      s_req <= 1'b0;
      if (!w)
         chk(s_rdata, er);
      chk({31'h0, s_err}, {31'h0, ee});
      @(posedge core_clk);
   endtask
   // One-cycle end-of-data-access pulse
   task automatic pulse(input logic d, e, a);
      data_access_done <= d;
      data_access_err <= e;
      data_access_abort <= a;
      @(posedge core_clk);
      {data_access_done, data_access_err, data_access_abort} <= 3'h0;
      @(posedge core_clk);
   endtask
   task automatic t_regs;
      chk({29'h0, m_pprot}, 32'h3);
      acc(0, 12'hd00, 0, 32'h30800042, 0);
      acc(1, 12'h010, 32'hffffffff, 0, 0);
      acc(1, 12'hd00, 32'h1000f010, 0, 0);
      acc(0, 12'hd00, 0, 32'h10800052, 0);
      chk({29'h0, m_pprot}, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_window;
      acc(1, 12'hd04, 32'h12345678, 0, 0);
      stall <= 2'h2;
      acc(1, 12'h3fc, 32'ha5a50001, 0, 0);
      chk(last_addr, 32'h123457fc);
      chk(last_wdata, 32'ha5a50001);
      stall <= 2'h0;
      acc(0, 12'h3fc, 0, 32'ha5a50001, 0);
      $display("test window done");
   endtask
   task automatic t_secure;
      secure_port_enable_in <= 1'b0;
      acc(0, 12'hd00, 0, 32'h10000052, 0);
      acc(0, 12'h3fc, 0, 0, 1);
      acc(1, 12'hd00, 32'h30010010, 0, 0);
      acc(0, 12'h3fc, 0, 32'ha5a50001, 0);
      port_enable_in <= 1'b0;
      acc(0, 12'hd00, 0, 32'h30010012, 0);
      acc(0, 12'h3fc, 0, 0, 0);
      port_enable_in <= 1'b1;
      secure_port_enable_in <= 1'b1;
      acc(1, 12'hd00, 32'h30000010, 0, 0);
      $display("test secure done");
   endtask
   task automatic t_halt;
      fail <= 1'b1;
      acc(1, 12'h3fc, 32'h7, 0, 1);
      acc(1, 12'hd00, 32'h30020010, 0, 0);
      acc(1, 12'h3fc, 32'h1, 0, 1);
      fail <= 1'b0;
      acc(1, 12'h3fc, 32'h2, 0, 1);
      chk(last_wdata, 32'h1);
      acc(1, 12'hd00, 32'h30000010, 0, 0);
      acc(1, 12'h3fc, 32'h3, 0, 0);
      chk(last_wdata, 32'h3);
      $display("test halt done");
   endtask
   task automatic t_inc;
      acc(1, 12'hd04, 32'h000003fc, 0, 0);
      pulse(1, 1, 0);
      pulse(1, 0, 1);
      acc(1, 12'h3fc, 32'h4, 0, 0);
      chk(last_addr, 32'h000003fc);
      pulse(1, 0, 0);
      acc(1, 12'h3fc, 32'h5, 0, 0);
      chk(last_addr, 32'h000007fc);
      $display("test increment done");
   endtask
   // Reset, then every scenario in turn
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_regs();
      t_window();
      t_secure();
      t_halt();
      t_inc();
      wrap_up();
   end
endmodule
